// ### design/bi_pkg.sv
// Shared constants and types for the block memory init and output preset logic
package bi_pkg;

	// ==========================================================================
	// Array geometry
	localparam int DATA_W   = 32;
	localparam int PAR_W    = (DATA_W >= 8) ? DATA_W / 8 : 0;
	localparam int WORD_W   = DATA_W + PAR_W;
	localparam int DEPTH    = 512;
	localparam int ADDR_W   = 9;

	// ==========================================================================
	// Preload vectors
	localparam int          VEC_W       = 256;
	localparam int          CHUNK_W     = 32;
	localparam int          CHUNKS      = VEC_W / CHUNK_W;
	localparam logic [6:0]  DATA_VECS   = 7'h40;
	localparam logic [6:0]  PAR_VEC_END = 7'h48;
	localparam logic [2:0]  LAST_LANE   = 3'h7;
	localparam logic [8:0]  LAST_WORD   = 9'h1FF;

	// ==========================================================================
	// APB register map, byte offsets
	localparam int         PADDR_W      = 12;
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_STATUS    = 12'h004;
	localparam logic [11:0] REG_PL_SEL    = 12'h008;
	localparam logic [11:0] REG_PL_DATA   = 12'h00C;
	localparam logic [11:0] REG_START_AD  = 12'h010;
	localparam logic [11:0] REG_START_AP  = 12'h014;
	localparam logic [11:0] REG_START_BD  = 12'h018;
	localparam logic [11:0] REG_START_BP  = 12'h01C;
	localparam logic [11:0] REG_PRESET_AD = 12'h020;
	localparam logic [11:0] REG_PRESET_AP = 12'h024;
	localparam logic [11:0] REG_PRESET_BD = 12'h028;
	localparam logic [11:0] REG_PRESET_BP = 12'h02C;

	// Field positions
	localparam int CTRL_CFG_START  = 0;
	localparam int CTRL_CFG_DONE   = 1;
	localparam int CTRL_GLB_PRESET = 2;
	localparam int SEL_VEC_LSB     = 0;
	localparam int SEL_CHUNK_LSB   = 8;

	// Reset values
	localparam logic [WORD_W-1:0] STARTUP_RST = '0;
	localparam logic [WORD_W-1:0] PRESET_RST  = '0;

	// ==========================================================================
	// Configuration sequencer states
	typedef enum logic [1:0] {
		BI_ST_CLEAR   = 2'h0,
		BI_ST_PRELOAD = 2'h1,
		BI_ST_PARITY  = 2'h2,
		BI_ST_RUN     = 2'h3
	} bi_state_e;

endpackage : bi_pkg

// ### design/bi_dp_mem.sv
// Dual-port bit-masked memory array with registered read data
`timescale 1ns/1ps
`default_nettype none
module bi_dp_mem #(
	parameter int W     = 36,
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          a_en,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [W-1:0]  a_mask,
	input  wire logic [W-1:0]  a_wdata,
	output logic      [W-1:0]  a_rdata,
	input  wire logic          b_en,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [W-1:0]  b_mask,
	input  wire logic [W-1:0]  b_wdata,
	output logic      [W-1:0]  b_rdata
);

	// ==========================================================================
	// State
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            rd_a;
		logic [W-1:0]            rd_b;
	} bi_mem_s;

	bi_mem_s st_r;
	bi_mem_s st_nxt;

	// Reads return the old word; port B write lands last on an address clash
	always_comb begin
		st_nxt = st_r;
		if (a_en) begin
			st_nxt.rd_a = st_r.mem[a_addr];
		end
		if (b_en) begin
			st_nxt.rd_b = st_r.mem[b_addr];
		end
		if (a_en && a_we) begin
			st_nxt.mem[a_addr] = (st_nxt.mem[a_addr] & ~a_mask) | (a_wdata & a_mask);
		end
		if (b_en && b_we) begin
			st_nxt.mem[b_addr] = (st_nxt.mem[b_addr] & ~b_mask) | (b_wdata & b_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign a_rdata = st_r.rd_a;
	assign b_rdata = st_r.rd_b;

endmodule : bi_dp_mem
`default_nettype wire

// ### design/bi_out_latch.sv
// Per-port output latch with startup load and synchronous preset
`timescale 1ns/1ps
`default_nettype none
module bi_out_latch #(
	parameter int W = 36
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         rd_en,
	input  wire logic         sync_preset,
	input  wire logic         load_startup,
	input  wire logic [W-1:0] startup_val,
	input  wire logic [W-1:0] preset_val,
	input  wire logic [W-1:0] mem_rdata,
	output logic      [W-1:0] dout
);

	// ==========================================================================
	// State
	typedef struct packed {
		logic [W-1:0] dout;
		logic         pend;
	} bi_lat_s;

	bi_lat_s st_r;
	bi_lat_s st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.pend = rd_en && !sync_preset;
		if (load_startup) begin
			st_nxt.dout = startup_val; // RQ7
			st_nxt.pend = 1'b0;
		end else if (rd_en && sync_preset) begin
			st_nxt.dout = preset_val; // RQ11
		end else if (st_r.pend) begin
			st_nxt.dout = mem_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt; // RQ16
		end
	end

	assign dout = st_r.dout;

endmodule : bi_out_latch
`default_nettype wire

// ### design/bi_bram_init.sv
// Block memory with configuration preload, write shielding and output latch presets
// ============================================================================
// Function
// (RQ1) Every memory cell is cleared to zero during configuration unless preloaded.
// (RQ2) Port writes are ignored on both ports while configuration runs.
// (RQ3) Sixty-four data preload vectors of 256 bits, indices 0x00 to 0x3F, are accepted.
// (RQ4) Data vector k fills data bits k*256 (its LSB) up to (k+1)*256-1.
// (RQ5) Any data location not preloaded is left at zero.
// (RQ6) Eight 256-bit parity preload vectors use the same mapping and default to zero.
// (RQ7) Output latches take the port startup value after configuration and on global preset.
// (RQ8) Each port keeps its own startup value.
// (RQ9) A port without a startup value loads all zeros.
// (RQ10) Startup and preset values carry parity bits above the data bits.
// (RQ11) The port sync preset input loads the port preset value into its output latch; here only with the port enable high, on port A only outside configuration.
// (RQ12) Each port keeps its own preset value.
// (RQ13) A port without a preset value presets to all zeros.
// (RQ14) Preset values cover data and parity bits and reset to zero.
// (RQ15) Parity bits exist only on ports at least eight bits wide.
// (RQ16) Sync preset acts on the port clock edge while the input is held across it.
`timescale 1ns/1ps
`default_nettype none
module bi_bram_init (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [bi_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       global_preset_signal,
	input  wire logic                       a_en,
	input  wire logic                       a_we,
	input  wire logic [bi_pkg::ADDR_W-1:0]  a_addr,
	input  wire logic [bi_pkg::DATA_W-1:0]  a_din,
	input  wire logic [bi_pkg::PAR_W-1:0]   a_parity_in_bus,
	input  wire logic                       a_output_sync_preset_input,
	output logic      [bi_pkg::DATA_W-1:0]  a_dout,
	output logic      [bi_pkg::PAR_W-1:0]   a_parity_out_bus,
	input  wire logic                       b_en,
	input  wire logic                       b_we,
	input  wire logic [bi_pkg::ADDR_W-1:0]  b_addr,
	input  wire logic [bi_pkg::DATA_W-1:0]  b_din,
	input  wire logic [bi_pkg::PAR_W-1:0]   b_parity_in_bus,
	input  wire logic                       b_output_sync_preset_input,
	output logic      [bi_pkg::DATA_W-1:0]  b_dout,
	output logic      [bi_pkg::PAR_W-1:0]   b_parity_out_bus,
	output logic                            cfg_busy
);

	localparam int W  = bi_pkg::WORD_W;
	localparam int DW = bi_pkg::DATA_W;
	localparam int AW = bi_pkg::ADDR_W;

	// ==========================================================================
	// State
	typedef struct packed {
		bi_pkg::bi_state_e st;
		logic [AW-1:0]     clr_addr;
		logic [6:0]        sel_vec;
		logic [2:0]        sel_chunk;
		logic [31:0]       par_word;
		logic [2:0]        par_cnt;
		logic              eng_we;
		logic [AW-1:0]     eng_addr;
		logic [W-1:0]      eng_wdata;
		logic [W-1:0]      eng_mask;
		logic              load_pulse;
		logic [W-1:0]      startup_a;
		logic [W-1:0]      startup_b;
		logic [W-1:0]      preset_a;
		logic [W-1:0]      preset_b;
		logic [31:0]       prdata;
		logic              gps_s0;
		logic              gps_s1;
		logic              gps_prev;
	} bi_top_s;

	bi_top_s st_r;
	bi_top_s st_nxt;

	// ==========================================================================
	// Bus decode
	logic       busy;
	logic       acc;
	logic       wr;
	logic       rd_setup;
	logic       mapped;
	logic [W-1:0] mask_data;
	logic [W-1:0] mask_par;
	logic [W-1:0] mem_a_rdata;
	logic [W-1:0] mem_b_rdata;
	logic [W-1:0] lat_a;
	logic [W-1:0] lat_b;
	logic         glb_edge;
	logic         ctrl_wr;
	logic         mem_a_en;
	logic         mem_a_we;
	logic [AW-1:0] mem_a_addr;
	logic [W-1:0] mem_a_mask;
	logic [W-1:0] mem_a_wdata;
	logic         mem_b_we;

	// Ports see configuration until done is written
	assign busy      = (st_r.st != bi_pkg::BI_ST_RUN);
	// Wait states only while parity bits spread out
	assign pready    = (st_r.st != bi_pkg::BI_ST_PARITY);
	// An access ends only at an edge with pready high
	assign acc       = psel && penable && pready;
	assign wr        = acc && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	// Preload touches data or parity lanes, never both
	assign mask_data = {{bi_pkg::PAR_W{1'b0}}, {DW{1'b1}}};
	assign mask_par  = {{bi_pkg::PAR_W{1'b1}}, {DW{1'b0}}};

	always_comb begin
		unique case (paddr)
			bi_pkg::REG_CTRL,
			bi_pkg::REG_STATUS,
			bi_pkg::REG_PL_SEL,
			bi_pkg::REG_PL_DATA,
			bi_pkg::REG_START_AD,
			bi_pkg::REG_START_AP,
			bi_pkg::REG_START_BD,
			bi_pkg::REG_START_BP,
			bi_pkg::REG_PRESET_AD,
			bi_pkg::REG_PRESET_AP,
			bi_pkg::REG_PRESET_BD,
			bi_pkg::REG_PRESET_BP: mapped = 1'b1;
			default:               mapped = 1'b0;
		endcase
	end

	// Unmapped addresses answer with an error and read zero
	assign pslverr = acc && !mapped;
	assign ctrl_wr = wr && paddr == bi_pkg::REG_CTRL;

	// Edge, not level: a held pin reloads once
	assign glb_edge = st_r.gps_s1 && !st_r.gps_prev;

	// ==========================================================================
	// Next state
	always_comb begin
		st_nxt            = st_r;
		// Strobes last one cycle unless set below
		st_nxt.eng_we     = 1'b0;
		st_nxt.load_pulse = 1'b0;

		// Global preset pin crosses in through two flops, then edge detect
		st_nxt.gps_s0   = global_preset_signal;
		st_nxt.gps_s1   = st_r.gps_s0;
		st_nxt.gps_prev = st_r.gps_s1;

		// Read data captured at setup so it is stable through the access phase
		if (rd_setup) begin
			unique case (paddr)
				bi_pkg::REG_STATUS:    st_nxt.prdata = {29'h0, st_r.st, busy};
				bi_pkg::REG_PL_SEL:    st_nxt.prdata = {21'h0, st_r.sel_chunk, 1'b0,
				                                        st_r.sel_vec};
				bi_pkg::REG_START_AD:  st_nxt.prdata = st_r.startup_a[DW-1:0];
				bi_pkg::REG_START_AP:  st_nxt.prdata = {28'h0, st_r.startup_a[W-1:DW]};
				bi_pkg::REG_START_BD:  st_nxt.prdata = st_r.startup_b[DW-1:0];
				bi_pkg::REG_START_BP:  st_nxt.prdata = {28'h0, st_r.startup_b[W-1:DW]};
				bi_pkg::REG_PRESET_AD: st_nxt.prdata = st_r.preset_a[DW-1:0];
				bi_pkg::REG_PRESET_AP: st_nxt.prdata = {28'h0, st_r.preset_a[W-1:DW]};
				bi_pkg::REG_PRESET_BD: st_nxt.prdata = st_r.preset_b[DW-1:0];
				bi_pkg::REG_PRESET_BP: st_nxt.prdata = {28'h0, st_r.preset_b[W-1:DW]};
				// CTRL and PL_DATA read as zero
				default:               st_nxt.prdata = 32'h0;
			endcase
		end

		// Per-port values, parity above data, zero from reset
		// Writable in any state; they act at the next load
		if (wr) begin
			unique case (paddr)
				bi_pkg::REG_START_AD:  st_nxt.startup_a[DW-1:0] = pwdata; // RQ8
				bi_pkg::REG_START_AP:  st_nxt.startup_a[W-1:DW] = pwdata[3:0]; // RQ10
				bi_pkg::REG_START_BD:  st_nxt.startup_b[DW-1:0] = pwdata; // RQ8
				bi_pkg::REG_START_BP:  st_nxt.startup_b[W-1:DW] = pwdata[3:0]; // RQ10
				bi_pkg::REG_PRESET_AD: st_nxt.preset_a[DW-1:0]  = pwdata; // RQ12
				bi_pkg::REG_PRESET_AP: st_nxt.preset_a[W-1:DW]  = pwdata[3:0]; // RQ14
				bi_pkg::REG_PRESET_BD: st_nxt.preset_b[DW-1:0]  = pwdata; // RQ12
				bi_pkg::REG_PRESET_BP: st_nxt.preset_b[W-1:DW]  = pwdata[3:0]; // RQ14
				bi_pkg::REG_PL_SEL: begin
					st_nxt.sel_vec   = pwdata[bi_pkg::SEL_VEC_LSB +: 7];
					st_nxt.sel_chunk = pwdata[bi_pkg::SEL_CHUNK_LSB +: 3];
				end
				default: ;
			endcase
		end

		// Configuration sequencer
		unique case (st_r.st)
			bi_pkg::BI_ST_CLEAR: begin
				// Whole array first, so unloaded words stay zero
				st_nxt.eng_we    = 1'b1;
				st_nxt.eng_addr  = st_r.clr_addr;
				st_nxt.eng_wdata = '0; // RQ1
				st_nxt.eng_mask  = '1;
				st_nxt.clr_addr  = st_r.clr_addr + 9'h001;
				if (st_r.clr_addr == bi_pkg::LAST_WORD) begin
					st_nxt.st = bi_pkg::BI_ST_PRELOAD; // RQ5
				end
			end
			bi_pkg::BI_ST_PRELOAD: begin
				// Chunk index wraps: a ninth chunk hits chunk zero
				if (wr && paddr == bi_pkg::REG_PL_DATA) begin
					if (st_r.sel_vec < bi_pkg::DATA_VECS) begin
						st_nxt.eng_we    = 1'b1; // RQ3
						st_nxt.eng_addr  = {st_r.sel_vec[5:0], st_r.sel_chunk}; // RQ4
						st_nxt.eng_wdata = {{bi_pkg::PAR_W{1'b0}}, pwdata};
						st_nxt.eng_mask  = mask_data;
						st_nxt.sel_chunk = st_r.sel_chunk + 3'h1;
					end else if (st_r.sel_vec < bi_pkg::PAR_VEC_END) begin
						st_nxt.par_word = pwdata; // RQ6
						st_nxt.par_cnt  = 3'h0;
						st_nxt.st       = bi_pkg::BI_ST_PARITY;
					end
				end else if (ctrl_wr && pwdata[bi_pkg::CTRL_CFG_DONE]) begin
					st_nxt.st         = bi_pkg::BI_ST_RUN;
					st_nxt.load_pulse = 1'b1; // RQ7
				end
			end
			bi_pkg::BI_ST_PARITY: begin
				// Each 32-bit chunk spreads over eight words, four parity bits each
				st_nxt.eng_we    = 1'b1; // RQ6
				st_nxt.eng_addr  = {st_r.sel_vec[2:0], st_r.sel_chunk, st_r.par_cnt};
				st_nxt.eng_wdata = {st_r.par_word[{st_r.par_cnt, 2'h0} +: 4], {DW{1'b0}}};
				st_nxt.eng_mask  = mask_par;
				st_nxt.par_cnt   = st_r.par_cnt + 3'h1;
				if (st_r.par_cnt == bi_pkg::LAST_LANE) begin
					st_nxt.sel_chunk = st_r.sel_chunk + 3'h1;
					st_nxt.st        = bi_pkg::BI_ST_PRELOAD;
				end
			end
			bi_pkg::BI_ST_RUN: begin
				// Reconfiguring wipes the array; port values survive
				if (ctrl_wr && pwdata[bi_pkg::CTRL_CFG_START]) begin
					st_nxt.clr_addr = '0;
					st_nxt.st       = bi_pkg::BI_ST_CLEAR;
				end else if (ctrl_wr && pwdata[bi_pkg::CTRL_GLB_PRESET]) begin
					st_nxt.load_pulse = 1'b1; // RQ7
				end else if (glb_edge) begin
					st_nxt.load_pulse = 1'b1; // RQ7
				end
			end
		endcase
	end

	// Reset parks the sequencer in clear, so each release wipes the array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r           <= '0;
			st_r.st        <= bi_pkg::BI_ST_CLEAR;
			st_r.startup_a <= bi_pkg::STARTUP_RST; // RQ9
			st_r.startup_b <= bi_pkg::STARTUP_RST; // RQ9
			st_r.preset_a  <= bi_pkg::PRESET_RST; // RQ13
			st_r.preset_b  <= bi_pkg::PRESET_RST; // RQ13
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================================
	// Port steering
	// Port A is lent to the sequencer while configuration runs, so user
	// traffic on A is dropped entirely then; B may still read.
	assign mem_a_en    = busy ? st_r.eng_we : a_en;
	assign mem_a_we    = busy ? st_r.eng_we : a_we; // RQ2
	assign mem_a_addr  = busy ? st_r.eng_addr : a_addr;
	assign mem_a_mask  = busy ? st_r.eng_mask : {W{1'b1}};
	assign mem_a_wdata = busy ? st_r.eng_wdata : {a_parity_in_bus, a_din}; // RQ15
	assign mem_b_we    = b_we && !busy; // RQ2

	// ==========================================================================
	// Array and output latches
	bi_dp_mem #(
		.W     (W),
		.DEPTH (bi_pkg::DEPTH),
		.AW    (AW)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.a_en    (mem_a_en),
		.a_we    (mem_a_we),
		.a_addr  (mem_a_addr),
		.a_mask  (mem_a_mask),
		.a_wdata (mem_a_wdata),
		.a_rdata (mem_a_rdata),
		.b_en    (b_en),
		.b_we    (mem_b_we),
		.b_addr  (b_addr),
		.b_mask  ({W{1'b1}}),
		.b_wdata ({b_parity_in_bus, b_din}),
		.b_rdata (mem_b_rdata)
	);

	// One load pulse feeds both latches; values stay per port
	bi_out_latch #(
		.W (W)
	) u_lat_a (
		.pclk         (pclk),
		.presetn      (presetn),
		.rd_en        (a_en && !busy),
		.sync_preset  (a_output_sync_preset_input), // RQ11
		.load_startup (st_r.load_pulse),
		.startup_val  (st_r.startup_a),
		.preset_val   (st_r.preset_a),
		.mem_rdata    (mem_a_rdata),
		.dout         (lat_a)
	);

	bi_out_latch #(
		.W (W)
	) u_lat_b (
		.pclk         (pclk),
		.presetn      (presetn),
		// B reads stay live while configuration runs
		.rd_en        (b_en),
		.sync_preset  (b_output_sync_preset_input), // RQ11
		.load_startup (st_r.load_pulse),
		.startup_val  (st_r.startup_b),
		.preset_val   (st_r.preset_b),
		.mem_rdata    (mem_b_rdata),
		.dout         (lat_b)
	);

	// ==========================================================================
	// Outputs
	// Parity rides above data on both ports
	assign a_dout           = lat_a[DW-1:0];
	assign a_parity_out_bus = lat_a[W-1:DW]; // RQ10
	assign b_dout           = lat_b[DW-1:0];
	assign b_parity_out_bus = lat_b[W-1:DW]; // RQ10
	assign prdata           = st_r.prdata;
	assign cfg_busy         = busy;

endmodule : bi_bram_init
`default_nettype wire

// ### tb/bi_chk.sv
// Port-level assertion checker for the block memory init and preset logic
`timescale 1ns/1ps
`default_nettype none
module bi_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        global_preset_signal,
	input wire logic        a_output_sync_preset_input,
	input wire logic        a_en,
	input wire logic [31:0] a_dout,
	input wire logic [3:0]  a_parity_out_bus,
	input wire logic        b_output_sync_preset_input,
	input wire logic        b_en,
	input wire logic [31:0] b_dout,
	input wire logic [3:0]  b_parity_out_bus,
	input wire logic        cfg_busy
);
	// ==========
	// Shadow copies of the per-port values, so loads can be judged
	logic [35:0] st_a_r, st_b_r, pr_a_r, pr_b_r, qa, qb;
	logic        wr, done_w;
	assign wr = psel && penable && pready && pwrite;
	assign done_w = wr && paddr == bi_pkg::REG_CTRL && pwdata[1] && cfg_busy;
	assign qa = {a_parity_out_bus, a_dout};
	assign qb = {b_parity_out_bus, b_dout};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_a_r <= '0;
			st_b_r <= '0;
			pr_a_r <= '0;
			pr_b_r <= '0;
		end else if (wr) begin
			case (paddr)
				bi_pkg::REG_START_AD: st_a_r[31:0] <= pwdata;
				bi_pkg::REG_START_AP: st_a_r[35:32] <= pwdata[3:0];
				bi_pkg::REG_START_BD: st_b_r[31:0] <= pwdata;
				bi_pkg::REG_START_BP: st_b_r[35:32] <= pwdata[3:0];
				bi_pkg::REG_PRESET_AD: pr_a_r[31:0] <= pwdata;
				bi_pkg::REG_PRESET_AP: pr_a_r[35:32] <= pwdata[3:0];
				bi_pkg::REG_PRESET_BD: pr_b_r[31:0] <= pwdata;
				bi_pkg::REG_PRESET_BP: pr_b_r[35:32] <= pwdata[3:0];
				default: ;
			endcase
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_startup_a: assert property (done_w |-> ##2 qa == st_a_r)
		else $error("port A startup load wrong");
	b_startup_a: assert property (done_w |-> ##2 qb == st_b_r)
		else $error("port B startup load wrong");
	// Preset on the same edge as the startup load is excluded: the load wins there
	a_preset_a: assert property (a_en && a_output_sync_preset_input && !cfg_busy &&
		!$past(cfg_busy) |=> qa == pr_a_r) else $error("port A preset wrong");
	b_preset_a: assert property (b_en && b_output_sync_preset_input && !cfg_busy &&
		!$past(cfg_busy) |=> qb == pr_b_r) else $error("port B preset wrong");
	glb_reload_a: assert property ($rose(global_preset_signal) && !cfg_busy
		|-> ##[2:5] (qa == st_a_r && qb == st_b_r)) else $error("global reload wrong");
	busy_exit_a: assert property ($fell(cfg_busy) |-> $past(done_w))
		else $error("configuration ended without done");
	run_ready_a: assert property (!cfg_busy |-> pready)
		else $error("wait state outside configuration");
	bad_addr_a: assert property (psel && penable && paddr > bi_pkg::REG_PRESET_BP |-> pslverr)
		else $error("unmapped access not refused");
	good_addr_a: assert property (psel && penable && paddr <= bi_pkg::REG_PRESET_BP &&
		paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
	cover property (done_w);
	cover property (b_en && b_output_sync_preset_input && !cfg_busy);
	cover property ($rose(global_preset_signal) && !cfg_busy);
endmodule : bi_chk
bind bi_bram_init bi_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .global_preset_signal, .a_output_sync_preset_input, .a_en, .a_dout,
	.a_parity_out_bus, .b_output_sync_preset_input, .b_en, .b_dout, .b_parity_out_bus,
	.cfg_busy);
`default_nettype wire

// ### tb/bi_user_port.sv
// User fabric model driving one memory port
`timescale 1ns/1ps
`default_nettype none
module bi_user_port (
	input wire logic        pclk,
	output logic            en,
	output logic            we,
	output logic            sp,
	output logic [8:0]      addr,
	output logic [31:0]     din,
	output logic [3:0]      par,
	input wire logic [31:0] dout,
	input wire logic [3:0]  pout
);
	initial begin
		{en, we, sp} = 3'h0;
		addr = '0;
		{par, din} = '0;
	end
	// ==========
	// One request, held across its sampling edge
	task automatic go(input logic w, input logic s, input logic [8:0] a, input logic [35:0] d);
		@(posedge pclk);
		en <= 1'b1;
		we <= w;
		sp <= s;
		addr <= a;
		{par, din} <= d;
		@(posedge pclk);
		en <= 1'b0;
		we <= 1'b0;
		sp <= 1'b0;
		// Released data flips so a stale word never looks written
		{par, din} <= ~d;
	endtask : go
	task automatic rd(input logic [8:0] a, output logic [35:0] q);
		go(1'b0, 1'b0, a, '0);
		@(posedge pclk);
		#1 q = {pout, dout};
	endtask : rd
	task automatic pre(input logic [8:0] a, output logic [35:0] q);
		go(1'b0, 1'b1, a, '0);
		#1 q = {pout, dout};
	endtask : pre
endmodule : bi_user_port
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the block memory init and preset logic
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
	logic         global_preset_signal, cfg_busy, a_en, a_we, a_sp, b_en, b_we, b_sp;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rdv, a_din, b_din, a_dout, b_dout;
	logic [8:0]   a_addr, b_addr;
	logic [3:0]   a_par, b_par, a_pout, b_pout;
	logic [5:0]   vk [2];
	logic [255:0] vv [2];
	logic [255:0] pv;
	logic [2:0]   pk;
	int           failures = 0;
	int           cmp_count = 0;
	bi_bram_init dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .global_preset_signal, .cfg_busy, .a_en, .a_we, .a_addr, .a_din,
		.a_parity_in_bus(a_par), .a_output_sync_preset_input(a_sp), .a_dout,
		.a_parity_out_bus(a_pout), .b_en, .b_we, .b_addr, .b_din, .b_parity_in_bus(b_par),
		.b_output_sync_preset_input(b_sp), .b_dout, .b_parity_out_bus(b_pout));
	bi_user_port u_a (.pclk, .en(a_en), .we(a_we), .sp(a_sp), .addr(a_addr), .din(a_din),
		.par(a_par), .dout(a_dout), .pout(a_pout));
	bi_user_port u_b (.pclk, .en(b_en), .we(b_we), .sp(b_sp), .addr(b_addr), .din(b_din),
		.par(b_par), .dout(b_dout), .pout(b_pout));
	// ==========
	// Helpers
	function automatic logic [35:0] r36();
		return {4'($urandom), $urandom};
	endfunction : r36
	function automatic logic [35:0] exp_w(input logic [8:0] w);
		logic [35:0] r;
		r = '0;
		for (int j = 0; j < 2; j++)
			if (w[8:3] == vk[j]) r[31:0] = vv[j][w[2:0]*32 +: 32];
		if (w[8:6] == pk) r[35:32] = pv[w[5:0]*4 +: 4];
		return r;
	endfunction : exp_w
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) chk("pready", 36'h1, 36'h0);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic pl(input logic [6:0] k, input logic [255:0] v);
		wr(bi_pkg::REG_PL_SEL, {25'h0, k});
		for (int i = 0; i < 8; i++) wr(bi_pkg::REG_PL_DATA, v[i*32 +: 32]);
	endtask : pl
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	// ==========
	// Clock, watchdog and main sequence
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#2000000;
		failures++;
		test_done();
	end
	initial begin
		logic [35:0] q, sa, pb, d;
		logic [8:0]  w, ws;
		int          n;
		{presetn, psel, penable, pwrite, global_preset_signal} = 5'h0;
		paddr = '0;
		pwdata = '0;
		void'($urandom(40780));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		do begin
			rd(bi_pkg::REG_STATUS);
			n++;
		end while (rdv[2:1] !== 2'h1 && n < 400);
		chk("status", 36'h3, {4'h0, rdv});
		ws = 9'($urandom);
		u_b.go(1'b1, 1'b0, ws, r36());
		u_a.go(1'b1, 1'b0, ws + 9'h1, r36());
		vk[0] = 6'h3F;
		vk[1] = 6'($urandom_range(62));
		pk = 3'($urandom);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) vv[j][i*32 +: 32] = $urandom;
			pl(7'(vk[j]), vv[j]);
		end
		for (int i = 0; i < 8; i++) pv[i*32 +: 32] = $urandom;
		pl(7'h40 + 7'(pk), pv);
		rd(bi_pkg::REG_PRESET_BP);
		chk("preset_b_rst", 36'h0, {4'h0, rdv});
		sa = r36();
		pb = r36();
		wr(bi_pkg::REG_START_AD, sa[31:0]);
		wr(bi_pkg::REG_START_AP, {28'h0, sa[35:32]});
		wr(bi_pkg::REG_PRESET_BD, pb[31:0]);
		wr(bi_pkg::REG_PRESET_BP, {28'h0, pb[35:32]});
		rd(bi_pkg::REG_START_AP);
		chk("start_a_par", {32'h0, sa[35:32]}, {4'h0, rdv});
		wr(bi_pkg::REG_CTRL, 32'h2);
		repeat (2) @(posedge pclk);
		#1 chk("start_a", sa, {a_pout, a_dout});
		chk("start_b", 36'h0, {b_pout, b_dout});
		for (int i = 0; i < 8; i++) begin
			case (i % 4)
				0: w = {vk[0], 3'($urandom)};
				1: w = {vk[1], 3'($urandom)};
				2: w = {pk, 6'($urandom)};
				default: w = ws + 9'(i / 4);
			endcase
			if (i < 4) u_a.rd(w, q);
			else u_b.rd(w, q);
			chk("mem_word", exp_w(w), q);
		end
		u_a.pre(9'($urandom), q);
		chk("preset_a", 36'h0, q);
		u_b.pre(9'($urandom), q);
		chk("preset_b", pb, q);
		for (int i = 0; i < 6; i++) begin
			w = 9'($urandom);
			d = r36();
			if (i[0]) u_a.go(1'b1, 1'b0, w, d);
			else u_b.go(1'b1, 1'b0, w, d);
			if (i[0]) u_b.rd(w, q);
			else u_a.rd(w, q);
			chk("run_word", d, q);
		end
		@(posedge pclk);
		global_preset_signal <= 1'b1;
		repeat (3) @(posedge pclk);
		global_preset_signal <= 1'b0;
		repeat (4) @(posedge pclk);
		#1 chk("glb_a", sa, {a_pout, a_dout});
		chk("glb_b", 36'h0, {b_pout, b_dout});
		rd(12'h030);
		chk("slverr", 36'h1, {35'h0, erv});
		chk("unmapped_rd", 36'h0, {4'h0, rdv});
		u_a.pre(9'h0, q);
		chk("preset_a2", 36'h0, q);
		wr(bi_pkg::REG_CTRL, 32'h4);
		repeat (2) @(posedge pclk);
		#1 chk("ctrl_glb_a", sa, {a_pout, a_dout});
		wr(bi_pkg::REG_CTRL, 32'h1);
		n = 0;
		do begin
			rd(bi_pkg::REG_STATUS);
			n++;
		end while (rdv[2:1] !== 2'h1 && n < 400);
		u_b.rd(w, q);
		chk("reclear", 36'h0, q);
		test_done();
	end
endmodule : tb
`default_nettype wire
